// ===== pisr_pkg.sv
// Purpose: constants and types for the management event/status registers
// Assumes: 16-bit registers reached by 5-bit register address over MDIO
// Notes:   offsets, register reset values and single-bit field positions live here; status fields are placed in pisr_regs
//
// Behaviour
// - diagnostic done latches interrupt status bit ten
// - sync loss latches bit nine under preamble suppression
// - one full-preamble frame restores management sync
// - event bits eight..one latch high, reset zero
// - pending bit zero when unmasked latched event
// - interrupt pin driven low while pending
// - mask bits ten..one enable matching events
// - mask bit zero gates pin, resets off
// - force-interrupt control bit asserts the pin
// - standby bit follows cleared link-allow control
// - fault field encodes fault, never reports 11b
// - status bit twelve shows negotiation complete
// - status bit eleven shows pair swap
// - bit ten shows inverted polarity at 10M, set while speed undetermined
// - speed field 9:8, undetermined 11b at reset
// - status bit seven shows full duplex
// - status bit six shows link up
// - status bit five shows transmitting
// - status bit four shows receiving
// - status bit three shows collision

package pisr_pkg;

  // register addresses
  localparam logic [4:0]  PISR_REG_BASIC    = 5'h00;
  localparam logic [4:0]  PISR_REG_CTRL     = 5'h17;
  localparam logic [4:0]  PISR_REG_MASK     = 5'h18;
  localparam logic [4:0]  PISR_REG_EVT      = 5'h19;
  localparam logic [4:0]  PISR_REG_STAT     = 5'h1a;

  // field positions
  localparam int          PISR_PRESUP_BIT   = 6;
  localparam int          PISR_LNKEN_BIT    = 13;
  localparam int          PISR_FORCE_BIT    = 0;
  localparam int          PISR_PINEN_BIT    = 0;
  localparam int          PISR_SYNC_BIT     = 9;
  localparam int          PISR_DIAG_BIT     = 10;

  // reset values and writable masks
  localparam logic [15:0] PISR_CTRL_RST     = 16'h3048;
  localparam logic [15:0] PISR_CTRL_WMASK   = 16'h3c7d;
  localparam logic [15:0] PISR_MASK_WMASK   = 16'h07ff;
  localparam logic [15:0] PISR_BASIC_WMASK  = 16'h0040;
  localparam logic [15:0] PISR_ZERO16       = 16'h0000;
  localparam logic [15:0] PISR_STAT_RST     = 16'h0700;

  // frame timing in mdc bits
  localparam logic [5:0]  PISR_PRE_LEN      = 6'h20;
  localparam logic [4:0]  PISR_HDR_LAST     = 5'h0b;
  localparam logic [4:0]  PISR_DATA_LEN     = 5'h10;
  localparam logic [4:0]  PISR_WR_LAST      = 5'h11;

  // encodings
  localparam logic [1:0]  PISR_OP_RD        = 2'h2;
  localparam logic [1:0]  PISR_OP_WR        = 2'h1;
  localparam logic [1:0]  PISR_FLT_RSVD     = 2'h3;
  localparam logic [1:0]  PISR_FLT_NONE     = 2'h0;
  localparam logic [1:0]  PISR_SPD_10       = 2'h0;
  localparam logic [1:0]  PISR_SPD_UNK      = 2'h3;
  localparam logic [4:0]  PISR_PHY_ADDR_DEF = 5'h01;

  typedef enum logic [2:0] {
    PISR_IDLE,
    PISR_START,
    PISR_HDR,
    PISR_RTA,
    PISR_RDAT,
    PISR_WDAT,
    PISR_SKIP
  } pisr_state_t;

endpackage

// ===== pisr_sync2.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous to ref_clk
// Notes:   only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none

module pisr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== pisr_regs.sv
// Purpose: MDIO slave holding event latch, mask, control and line status
// Assumes: core status and event inputs are on ref_clk; mdc/mdio are not
// Notes:   mdc is oversampled by ref_clk; data taken on mdc rising edges
`timescale 1ns/100ps
`default_nettype none

module pisr_regs
  import pisr_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PISR_PHY_ADDR_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic       diag_done,
  input  wire logic [7:0] core_evt,
  input  wire logic [1:0] an_fault,
  input  wire logic       an_done,
  input  wire logic       pair_swap,
  input  wire logic       pol_inv,
  input  wire logic [1:0] speed,
  input  wire logic       full_duplex,
  input  wire logic       link_up,
  input  wire logic       tx_active,
  input  wire logic       rx_active,
  input  wire logic       collision,
  output logic            mgmt_irq_out_n,
  output logic            link_allow,
  output logic            an_start
);

  logic [1:0]  pin_s;
  logic        mdc_s, mdio_s, mdc_d_q, rise;
  pisr_state_t st_q;
  logic [5:0]  ones_q;
  logic [4:0]  cnt_q;
  logic [11:0] hdr_q, hdr_d;
  logic [4:0]  ra_q;
  logic        presup, pre_full, start_ok, bad_st, hdr_end, op_bad;
  logic        sync_err, rd_hit, wr_hit, skip_hit, rd_evt, wr_now;
  logic        lost_q, pend_q;
  logic [10:1] evt_now, lat_q;
  logic [15:0] sh_q, wdata, basic_q, ctrl_q;
  logic [15:0] mask_q, stat_q, stat_d, rd_word;

  // mdc and mdio pass two flops before use
  pisr_sync2 #(.W(2)) u_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in ({mdc, mdio_in}),
    .sync_out (pin_s)
  );

  assign mdc_s  = pin_s[1];
  assign mdio_s = pin_s[0];

  // mdc rising edge finder
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      mdc_d_q <= 1'b0;
    else
      mdc_d_q <= mdc_s;
  end

  assign rise = mdc_s & ~mdc_d_q;

  // frame decode terms
  always_comb
  begin
    presup   = basic_q[PISR_PRESUP_BIT];
    pre_full = (ones_q >= PISR_PRE_LEN);
    hdr_d    = {hdr_q[10:0], mdio_s};
    start_ok = rise && (st_q == PISR_IDLE) && !mdio_s &&
               (pre_full || (presup && !lost_q));
    bad_st   = rise && (st_q == PISR_START) && !mdio_s;
    hdr_end  = rise && (st_q == PISR_HDR) && (cnt_q == PISR_HDR_LAST);
    op_bad   = hdr_end && (hdr_d[11:10] != PISR_OP_RD) &&
               (hdr_d[11:10] != PISR_OP_WR);
    sync_err = presup && (bad_st || op_bad);
    rd_hit   = hdr_end && (hdr_d[11:10] == PISR_OP_RD) &&
               (hdr_d[9:5] == PHY_ADDR);
    wr_hit   = hdr_end && (hdr_d[11:10] == PISR_OP_WR) &&
               (hdr_d[9:5] == PHY_ADDR);
    skip_hit = hdr_end && !op_bad && (hdr_d[9:5] != PHY_ADDR);
    rd_evt   = rd_hit && (hdr_d[4:0] == PISR_REG_EVT);
    wr_now   = rise && (st_q == PISR_WDAT) && (cnt_q == PISR_WR_LAST);
    wdata    = {sh_q[14:0], mdio_s};
  end

  // read data mux; unmapped addresses read zero
  always_comb
  begin
    unique case (hdr_d[4:0])
      PISR_REG_BASIC: rd_word = basic_q;
      PISR_REG_CTRL:  rd_word = ctrl_q;
      PISR_REG_MASK:  rd_word = mask_q;
      PISR_REG_EVT:   rd_word = {5'h00, lat_q, pend_q};
      PISR_REG_STAT:  rd_word = stat_q;
      default:        rd_word = PISR_ZERO16;
    endcase
  end

  // idle-line preamble counter
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ones_q <= '0;
    else if (rise)
    begin
      if (st_q != PISR_IDLE || !mdio_s)
        ones_q <= '0;
      else if (!pre_full)
        ones_q <= ones_q + 6'h01;
    end
  end

  // management frame state machine and pin drive
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q     <= PISR_IDLE;
      cnt_q    <= '0;
      hdr_q    <= '0;
      sh_q     <= '0;
      ra_q     <= '0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end
    else if (rise)
    begin
      unique case (st_q)
        PISR_IDLE:
          if (start_ok)
            st_q <= PISR_START;
        PISR_START:
        begin
          cnt_q <= '0;
          st_q  <= mdio_s ? PISR_HDR : PISR_IDLE;
        end
        PISR_HDR:
        begin
          hdr_q <= hdr_d;
          cnt_q <= cnt_q + 5'h01;
          if (hdr_end)
          begin
            cnt_q <= '0;
            ra_q  <= hdr_d[4:0];
            sh_q  <= rd_word; // value taken before the clear
            if (rd_hit)
              st_q <= PISR_RTA;
            else if (wr_hit)
              st_q <= PISR_WDAT;
            else if (skip_hit)
              st_q <= PISR_SKIP;
            else
              st_q <= PISR_IDLE;
          end
        end
        PISR_RTA:
        begin
          mdio_oe  <= 1'b1; // second turnaround bit driven low
          mdio_out <= 1'b0;
          st_q     <= PISR_RDAT;
        end
        PISR_RDAT:
          if (cnt_q == PISR_DATA_LEN)
          begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
            st_q     <= PISR_IDLE;
          end
          else
          begin
            mdio_out <= sh_q[15];
            sh_q     <= {sh_q[14:0], 1'b0};
            cnt_q    <= cnt_q + 5'h01;
          end
        PISR_WDAT:
        begin
          sh_q  <= wdata;
          cnt_q <= cnt_q + 5'h01;
          if (wr_now)
            st_q <= PISR_IDLE;
        end
        PISR_SKIP:
        begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == PISR_WR_LAST)
            st_q <= PISR_IDLE;
        end
      endcase
    end
  end

  // sync-lost state: set by a bad frame under preamble suppression, left by a full preamble
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      lost_q <= 1'b0;
    else if (sync_err)
      lost_q <= 1'b1;
    else if (start_ok && pre_full)
      lost_q <= 1'b0;
  end

  // event sources; bit nine is present while sync is lost
  assign evt_now = {diag_done, lost_q, core_evt};

  // latched-high events; a new event beats the read clear
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      lat_q <= '0;
    else if (rd_evt)
      lat_q <= evt_now;
    else
      lat_q <= lat_q | evt_now;
  end

  // pending flag from unmasked latched events
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pend_q <= 1'b0;
    else
      pend_q <= |(lat_q & mask_q[10:1]);
  end

  // interrupt pin: pending or forced, gated by pin enable
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      mgmt_irq_out_n <= 1'b1;
    else
      mgmt_irq_out_n <= ~(mask_q[PISR_PINEN_BIT] &
                          (pend_q | ctrl_q[PISR_FORCE_BIT]));
  end

  // writable registers; status registers ignore writes
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      basic_q <= PISR_ZERO16;
      ctrl_q  <= PISR_CTRL_RST;
      mask_q  <= PISR_ZERO16;
    end
    else if (wr_now)
    begin
      unique case (ra_q)
        PISR_REG_BASIC: basic_q <= wdata & PISR_BASIC_WMASK;
        PISR_REG_CTRL:  ctrl_q  <= wdata & PISR_CTRL_WMASK;
        PISR_REG_MASK:  mask_q  <= wdata & PISR_MASK_WMASK;
        default:        ;
      endcase
    end
  end

  // link-allow out and auto-negotiation start on its rise
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_allow <= 1'b1;
      an_start   <= 1'b0;
    end
    else
    begin
      link_allow <= ctrl_q[PISR_LNKEN_BIT];
      an_start   <= ctrl_q[PISR_LNKEN_BIT] & ~link_allow;
    end
  end

  // line status word assembled from core state
  always_comb
  begin
    stat_d     = PISR_ZERO16;
    stat_d[15] = ~ctrl_q[PISR_LNKEN_BIT];
    stat_d[14:13] = (an_fault == PISR_FLT_RSVD) ? PISR_FLT_NONE
                                                : an_fault;
    stat_d[12] = an_done;
    stat_d[11] = pair_swap;
    if (speed == PISR_SPD_UNK)
      stat_d[10] = 1'b1;
    else
      stat_d[10] = (speed == PISR_SPD_10) & pol_inv;
    stat_d[9:8] = speed;
    stat_d[7]  = full_duplex;
    stat_d[6]  = link_up;
    stat_d[5]  = tx_active;
    stat_d[4]  = rx_active;
    stat_d[3]  = collision;
  end

  // status snapshot register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      stat_q <= PISR_STAT_RST;
    else
      stat_q <= stat_d;
  end

  // read turnaround is a two-step sequence
  sequence rd_turn_s;
    rise && (st_q == PISR_RTA);
  endsequence

  sequence drive_low_s;
    mdio_oe && !mdio_out;
  endsequence

  turn_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_turn_s |=> drive_low_s) else $error("no turnaround drive");

  pin_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 (mgmt_irq_out_n == !($past(mask_q[PISR_PINEN_BIT]) &&
         ($past(pend_q) || $past(ctrl_q[PISR_FORCE_BIT])))))
    else $error("interrupt pin level wrong");

  pend_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((lat_q & mask_q[10:1]) != 10'h000) |=> pend_q)
    else $error("pending flag missing");

  pin_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !mask_q[PISR_PINEN_BIT] |=> mgmt_irq_out_n)
    else $error("pin asserted while disabled");

  force_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ctrl_q[PISR_FORCE_BIT] && mask_q[PISR_PINEN_BIT]) |=> !mgmt_irq_out_n)
    else $error("forced interrupt not seen");

  evt_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core_evt != 8'h00) |=> ((lat_q[8:1] & $past(core_evt)) == $past(core_evt)))
    else $error("event not latched");

  diag_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    diag_done |=> lat_q[PISR_DIAG_BIT]) else $error("diag flag missing");

  sync_lost_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sync_err |=> ##1 lat_q[PISR_SYNC_BIT]) else $error("sync loss missed");

  resync_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (lost_q && start_ok && pre_full && !sync_err) |=> !lost_q)
    else $error("no resync on preamble");

  read_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_evt && !core_evt[0]) |=> !lat_q[1]) else $error("read clear failed");

  fault_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stat_q[14:13] != PISR_FLT_RSVD) else $error("reserved fault code");

  standby_bit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !ctrl_q[PISR_LNKEN_BIT] |=> stat_q[15]) else $error("standby not shown");

endmodule
`default_nettype wire

// ===== pisr_mdio_master.sv
// Purpose: management master model that clocks frames onto mdc/mdio
// Assumes: mdio has a pull-up, so a released line reads one
// Notes:   mdc stands low between frames; read bits taken before a rise
`timescale 1ns/100ps
`default_nettype none

module pisr_mdio_master (
  output logic      mdc,
  output logic      m_oe,
  output logic      m_out,
  input  wire logic mdio
);
  // idle: clock low, line released
  initial
  begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_out = 1'b1;
  end

  // one bit: data set while mdc low, line sampled just before the rise
  task automatic tick(input logic oe, input logic v, output logic s);
    m_oe = oe;
    m_out = v;
    #400 s = mdio;
    mdc = 1'b1;
    #400 mdc = 1'b0;
  endtask

  // whole frame: npre ones, start, op, addresses, turnaround, 16 data
  task automatic xfer(input int npre, input logic [1:0] op,
                      input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, pa, ra};
    rd = 16'h0000;
    #13;
    for (int i = 0; i < npre; i++)
      tick(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      tick(1'b1, hdr[i], s);
    for (int i = 0; i < 18; i++)
    begin
      if (op == 2'h2)
        tick(1'b0, 1'b1, s);
      else
        tick(1'b1, (i < 2) ? (i == 0) : wd[17-i], s);
      if (i > 1)
        rd = {rd[14:0], s};
    end
    m_oe = 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the event latch and line status block
// Assumes: one device at management address 1, mdc period 800 ns
// Notes:   random core levels and events from a fixed seed
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import pisr_pkg::*;
  logic        ref_clk, nrst, mdc, m_oe, m_out, mdio, mdio_out, mdio_oe;
  logic        diag_done, an_done, pair_swap, pol_inv, full_duplex;
  logic        link_up, tx_active, rx_active, collision, la, p;
  logic        mgmt_irq_out_n, link_allow, an_start;
  logic [7:0]  core_evt;
  logic [1:0]  an_fault, speed;
  logic [15:0] rd;
  logic [10:0] m;
  logic [8:0]  v;
  logic [9:0]  l;
  int          failures, n_checks;
  int          n_an;

  // count negotiation start pulses; only one 0->1 of link_allow is made
  always @(posedge ref_clk)
    if (an_start)
      n_an <= n_an + 1;

  // wire level: device drive, then master drive, else pull-up
  assign mdio = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);

  pisr_regs #(.PHY_ADDR(5'h01)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .diag_done(diag_done),
    .core_evt(core_evt), .an_fault(an_fault), .an_done(an_done),
    .pair_swap(pair_swap), .pol_inv(pol_inv), .speed(speed),
    .full_duplex(full_duplex), .link_up(link_up), .tx_active(tx_active),
    .rx_active(rx_active), .collision(collision),
    .mgmt_irq_out_n(mgmt_irq_out_n), .link_allow(link_allow),
    .an_start(an_start));

  pisr_mdio_master u_mst (.mdc(mdc), .m_oe(m_oe), .m_out(m_out),
                          .mdio(mdio));

  // 10 MHz system clock
  always #50 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rdr(input logic [4:0] ra, input int np);
    u_mst.xfer(np, PISR_OP_RD, 5'h01, ra, 16'h0000, rd);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wrr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    u_mst.xfer(32, PISR_OP_WR, 5'h01, ra, d, x);
    repeat (4) @(posedge ref_clk);
  endtask

  // one-cycle event pulse, diag on top
  task automatic pulse(input logic [8:0] e);
    @(posedge ref_clk);
    {diag_done, core_evt} <= e;
    @(posedge ref_clk);
    {diag_done, core_evt} <= 9'h000;
  endtask

  // expected line status from the levels driven now
  function automatic logic [15:0] st_exp();
    logic       pl;
    logic [1:0] f;
    pl = (speed == PISR_SPD_10) ? pol_inv : (speed == PISR_SPD_UNK);
    f = (an_fault == PISR_FLT_RSVD) ? PISR_FLT_NONE : an_fault;
    return {~la, f, an_done, pair_swap, pl, speed, full_duplex, link_up,
            tx_active, rx_active, collision, 3'h0};
  endfunction

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    la = 1'b1;
    {diag_done, core_evt, an_fault, an_done, pair_swap, pol_inv} = '0;
    {full_duplex, link_up, tx_active, rx_active, collision} = '0;
    speed = PISR_SPD_UNK;
    void'($urandom(3));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("pin", 16'h0001, {15'h0, mgmt_irq_out_n});
    rdr(PISR_REG_EVT, 32);
    chk("evt_rst", 16'h0000, rd);
    rdr(PISR_REG_MASK, 32);
    chk("mask_rst", 16'h0000, rd);
    wrr(PISR_REG_STAT, 16'hffff);
    rdr(PISR_REG_STAT, 32);
    chk("stat_rst", PISR_STAT_RST, rd);
    rdr(5'h05, 32);
    chk("unmapped", 16'h0000, rd);
    // random core levels, standby toggled in the middle
    for (int i = 0; i < 8; i++)
    begin
      la = (i != 3) && (i != 4);
      wrr(PISR_REG_CTRL, {PISR_CTRL_RST[15:14], la, PISR_CTRL_RST[12:0]});
      @(posedge ref_clk);
      {an_fault, an_done, pair_swap, pol_inv, speed, full_duplex, link_up,
       tx_active, rx_active, collision} <= 13'($urandom);
      rdr(PISR_REG_STAT, 32);
      chk("stat", st_exp(), rd);
      chk("link_allow", {15'h0, la}, {15'h0, link_allow});
    end
    // each core and diag event alone, then a second read shows it cleared
    for (int i = 0; i < 9; i++)
    begin
      v = 9'h001 << i;
      pulse(v);
      rdr(PISR_REG_EVT, 32);
      chk("evt", {5'h0, v[8], 1'b0, v[7:0], 1'b0}, rd);
      rdr(PISR_REG_EVT, 32);
      chk("evt_clr", 16'h0000, rd);
    end
    // random masks and events; first pass masks every event off
    for (int i = 0; i < 6; i++)
    begin
      m = (i == 0) ? 11'h001 : 11'($urandom);
      v = (i == 0) ? 9'h1ff : 9'($urandom);
      wrr(PISR_REG_MASK, {5'h0, m});
      pulse(v);
      repeat (4) @(posedge ref_clk);
      l = {v[8], 1'b0, v[7:0]};
      p = |(l & m[10:1]);
      chk("pin", {15'h0, ~(p & m[0])}, {15'h0, mgmt_irq_out_n});
      rdr(PISR_REG_EVT, 32);
      chk("evt_mask", {5'h0, l, p}, rd);
    end
    // forced request, gated by the pin enable
    wrr(PISR_REG_MASK, 16'h0001);
    wrr(PISR_REG_CTRL, PISR_CTRL_RST | 16'h0001);
    chk("force", 16'h0000, {15'h0, mgmt_irq_out_n});
    wrr(PISR_REG_MASK, 16'h0000);
    chk("gate", 16'h0001, {15'h0, mgmt_irq_out_n});
    wrr(PISR_REG_MASK, 16'h0001);
    wrr(PISR_REG_CTRL, PISR_CTRL_RST);
    chk("unforce", 16'h0001, {15'h0, mgmt_irq_out_n});
    // preamble suppression, bad opcode, ignored frame, resync
    wrr(PISR_REG_BASIC, 16'h0040);
    rdr(PISR_REG_EVT, 0);
    chk("nopre", 16'h0000, rd);
    u_mst.xfer(0, 2'h3, 5'h01, PISR_REG_EVT, 16'h0000, rd);
    repeat (4) @(posedge ref_clk);
    rdr(PISR_REG_EVT, 0);
    chk("ignored", 16'hffff, rd);
    rdr(PISR_REG_EVT, 32);
    chk("sync_lost", 16'h0200, rd);
    rdr(PISR_REG_EVT, 0);
    chk("resync", 16'h0000, rd);
    chk("an_start", 16'h0001, 16'(n_an));
    wrap_up();
  end

  // watchdog well past the expected run length
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
